// ---- design/buffer_port_if.sv ----
interface buffer_port_if #(
	parameter int AW = flash_pkg::BUF_AW,
	parameter int DW = flash_pkg::WORD_W
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- design/countdown_timer.sv ----
module countdown_timer #(
	parameter int W = flash_pkg::TMR_W
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
		logic         done;
	} tmr_state_t;

	tmr_state_t tmr_ff;
	tmr_state_t nxt_tmr;

	// Value of one expires two cycles after the load
	always_comb begin
		nxt_tmr = tmr_ff;
		nxt_tmr.done = 1'b0;
		if (load) begin
			nxt_tmr.cnt = value;
			nxt_tmr.run = 1'b1;
		end else if (tmr_ff.run) begin
			if (tmr_ff.cnt <= W'(1)) begin
				nxt_tmr.run = 1'b0;
				nxt_tmr.done = 1'b1;
			end else begin
				nxt_tmr.cnt = tmr_ff.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_ff <= '0;
		end else if (ce) begin
			tmr_ff <= nxt_tmr;
		end
	end

	assign expired = tmr_ff.done;
endmodule

// ---- design/flash_pkg.sv ----
package flash_pkg;

	// Bus and array geometry
	localparam int PADDR_W   = 8;
	localparam int FA_W      = 14;
	localparam int PAGE_LSB  = 6;
	localparam int WORD_W    = 16;
	localparam int BUF_AW    = 6;
	localparam int BUF_DEPTH = 64;
	localparam int IDX_W     = 7;
	localparam int TMR_W     = 17;

	// Timing: operation and read cycle counts derived from the time and the clock period
	localparam int CLK_PERIOD_NS = 40;
	localparam int OP_TIME_NS    = 2_200_000;
	localparam int OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;
	localparam int READ_TIME_NS  = 160;
	localparam int READ_CYCLES   = READ_TIME_NS / CLK_PERIOD_NS;
	localparam int UNLOCK_CYCLES = 256;

	// Register word index; byte address is index times four
	localparam logic [3:0] IDX_FLASH_ADDRESS_LOW = 4'h0;
	localparam logic [3:0] IDX_FLASH_ADDRESS_HIGH = 4'h1;
	localparam logic [3:0] IDX_FIRST_DATA_LOW = 4'h2;
	localparam logic [3:0] IDX_FIRST_DATA_HIGH = 4'h3;
	localparam logic [3:0] IDX_SECOND_DATA_LOW = 4'h4;
	localparam logic [3:0] IDX_SECOND_DATA_HIGH = 4'h5;
	localparam logic [3:0] IDX_THIRD_DATA_LOW = 4'h6;
	localparam logic [3:0] IDX_THIRD_DATA_HIGH = 4'h7;
	localparam logic [3:0] IDX_FOURTH_DATA_LOW = 4'h8;
	localparam logic [3:0] IDX_FOURTH_DATA_HIGH = 4'h9;
	localparam logic [3:0] IDX_FC0  = 4'ha;
	localparam logic [3:0] IDX_FC1  = 4'hb;
	localparam logic [3:0] IDX_FC2  = 4'hc;

	// Main control and buffer clear register fields
	localparam int FC0_ERASE_WRITE_ENABLED_FLAG   = 7;
	localparam int FC0_MODE_LO = 4;
	localparam int FC0_UNLOCK_SEQUENCE_TRIGGER   = 3;
	localparam int FC0_FWT     = 2;
	localparam int FC0_READ_ENABLE_BIT   = 1;
	localparam int FC0_FRD     = 0;
	localparam int FC2_BUFFER_CLEAR_BIT    = 0;

	// Operation mode codes
	localparam logic [2:0] MODE_WRITE  = 3'h0;
	localparam logic [2:0] MODE_ERASE  = 3'h1;
	localparam logic [2:0] MODE_READ   = 3'h3;
	localparam logic [2:0] MODE_UNLOCK = 3'h6;

	// Unlock bytes and chip reset key
	localparam logic [7:0] KEY_SECOND_DATA_LOW  = 8'h00;
	localparam logic [7:0] KEY_THIRD_DATA_LOW  = 8'h0d;
	localparam logic [7:0] KEY_FOURTH_DATA_LOW  = 8'hc3;
	localparam logic [7:0] KEY_SECOND_DATA_HIGH  = 8'h04;
	localparam logic [7:0] KEY_THIRD_DATA_HIGH  = 8'h09;
	localparam logic [7:0] KEY_FOURTH_DATA_HIGH  = 8'h40;
	localparam logic [7:0] RESET_KEY = 8'h55;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ERASE   = 3'b001,
		ST_WAIT_ER = 3'b010,
		ST_WRITE   = 3'b011,
		ST_WAIT_WR = 3'b100,
		ST_CLEAR   = 3'b101,
		ST_READ    = 3'b110,
		ST_WAIT_RD = 3'b111
	} seq_state_t;

endpackage

// ---- design/flash_self_program_control.sv ----
//Behaviour
//- Erase/write enabled flag is set only by hardware; software writing one is ignored.
//- Software clearing the enabled flag disables flash erase and write.
//- Mode field: 000 write, 001 page erase, 011 read, 110 unlock; others reserved.
//- Erase or write proceeds only after the unlock has succeeded.
//- Setting the unlock trigger starts a timer; hardware clears the trigger at expiry.
//- Write-start launches a flash write; hardware clears it when finished.
//- Read-enable must be high for any read; low blocks reads.
//- Read-start launches a flash read; hardware clears it when done.
//- CPU is halted while a read, erase or write is in progress.
//- Writing 55h to the chip reset pattern register resets the whole chip.
//- Buffer-clear bit starts clearing the write buffer; hardware drops it when done.
//- Upper seven bits of the buffer clear control register read zero.
//- Erased locations read 0000h; software blank-checks and repeats erase if needed.
//- Fourth data pair holds the fourth word, low and high byte, reset zero.
//- Unlock needs 00,0D,C3 in low and 04,09,40 in high data registers two to four.
//- Writing first data high loads the 16-bit word and increments the address.
//- Buffer holds 64 words; address increment stops at the page's last word.
//- Every write process ends with the whole write buffer cleared.
module flash_self_program_control #(
	parameter int OP_CYCLES     = flash_pkg::OP_CYCLES,
	parameter int READ_CYCLES   = flash_pkg::READ_CYCLES,
	parameter int UNLOCK_CYCLES = flash_pkg::UNLOCK_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         ce,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [flash_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Flash array port
	output logic      [flash_pkg::FA_W-1:0]   flash_addr,
	output logic      [flash_pkg::WORD_W-1:0] flash_wdata,
	output logic                              flash_prog,
	output logic                              flash_erase,
	output logic                              flash_read,
	input  wire logic [flash_pkg::WORD_W-1:0] flash_rdata,
	// System
	output logic                              cpu_stall,
	output logic                              chip_reset
);
	typedef struct packed {
		logic [flash_pkg::FA_W-1:0]                          addr;
		logic [flash_pkg::IDX_FOURTH_DATA_HIGH:flash_pkg::IDX_FIRST_DATA_LOW][7:0] fd;
		logic [7:0]                                          fc1;
		logic                                                erase_write_enabled_flag;
		logic [2:0]                                          mode;
		logic                                                unlock_sequence_trigger;
		logic                                                write_start_bit;
		logic                                                read_enable_bit;
		logic                                                read_start_bit;
		logic                                                buffer_clear_bit;
		flash_pkg::seq_state_t                               st;
		logic [flash_pkg::IDX_W-1:0]                         idx;
		logic                                                pready;
		logic [31:0]                                         prdata;
		logic                                                pslverr;
		logic                                                stall;
		logic                                                chip_rst;
		logic [flash_pkg::FA_W-1:0]                          fl_addr;
		logic [flash_pkg::WORD_W-1:0]                        fl_wdata;
		logic                                                fl_prog;
		logic                                                fl_erase;
		logic                                                fl_read;
	} ctl_state_t;

	ctl_state_t ctl_ff;
	ctl_state_t nxt_ctl;

	logic                         unlock_load;
	logic                         unlock_exp;
	logic                         op_load;
	logic [flash_pkg::TMR_W-1:0]  op_value;
	logic                         op_exp;
	logic                         setup;
	logic                         access;
	logic                         hit;
	logic [3:0]                   ridx;
	logic [2:0]                   wmode;
	logic [flash_pkg::BUF_AW-1:0] page_off;

	buffer_port_if bp ();

	write_buffer_mem u_buf (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.bp      (bp.mem)
	);

	countdown_timer #(.W(flash_pkg::TMR_W)) u_unlock_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.load    (unlock_load),
		.value   (flash_pkg::TMR_W'(UNLOCK_CYCLES)),
		.expired (unlock_exp)
	);

	countdown_timer #(.W(flash_pkg::TMR_W)) u_op_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.load    (op_load),
		.value   (op_value),
		.expired (op_exp)
	);

	// Word-aligned decode; returns {hit, index}
	function automatic logic [4:0] decode(input logic [flash_pkg::PADDR_W-1:0] a);
		logic [3:0] i;
		i = a[5:2];
		decode = {(a[1:0] == 2'h0) && (a[flash_pkg::PADDR_W-1:6] == '0)
			&& (i <= flash_pkg::IDX_FC2), i};
	endfunction

	function automatic logic [7:0] reg_value(input ctl_state_t c, input logic [3:0] i);
		case (i)
			flash_pkg::IDX_FLASH_ADDRESS_LOW: reg_value = c.addr[7:0];
			flash_pkg::IDX_FLASH_ADDRESS_HIGH: reg_value = {2'h0, c.addr[flash_pkg::FA_W-1:8]};
			flash_pkg::IDX_FC0:  reg_value = {c.erase_write_enabled_flag, c.mode, c.unlock_sequence_trigger, c.write_start_bit, c.read_enable_bit, c.read_start_bit};
			flash_pkg::IDX_FC1:  reg_value = c.fc1;
			flash_pkg::IDX_FC2:  reg_value = {7'h00, c.buffer_clear_bit};
			default:             reg_value = c.fd[i];
		endcase
	endfunction

	function automatic logic key_ok(input ctl_state_t c);
		key_ok = (c.fd[flash_pkg::IDX_SECOND_DATA_LOW] == flash_pkg::KEY_SECOND_DATA_LOW)
			&& (c.fd[flash_pkg::IDX_THIRD_DATA_LOW] == flash_pkg::KEY_THIRD_DATA_LOW)
			&& (c.fd[flash_pkg::IDX_FOURTH_DATA_LOW] == flash_pkg::KEY_FOURTH_DATA_LOW)
			&& (c.fd[flash_pkg::IDX_SECOND_DATA_HIGH] == flash_pkg::KEY_SECOND_DATA_HIGH)
			&& (c.fd[flash_pkg::IDX_THIRD_DATA_HIGH] == flash_pkg::KEY_THIRD_DATA_HIGH)
			&& (c.fd[flash_pkg::IDX_FOURTH_DATA_HIGH] == flash_pkg::KEY_FOURTH_DATA_HIGH);
	endfunction

	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_ctl.fl_prog = 1'b0;
		nxt_ctl.fl_erase = 1'b0;
		nxt_ctl.fl_read = 1'b0;
		nxt_ctl.chip_rst = 1'b0;
		unlock_load = 1'b0;
		op_load = 1'b0;
		op_value = flash_pkg::TMR_W'(OP_CYCLES);
		bp.we = 1'b0;
		bp.waddr = ctl_ff.addr[flash_pkg::BUF_AW-1:0];
		bp.wdata = {pwdata[7:0], ctl_ff.fd[flash_pkg::IDX_FIRST_DATA_LOW]};
		bp.raddr = ctl_ff.idx[flash_pkg::BUF_AW-1:0];
		page_off = ctl_ff.addr[flash_pkg::BUF_AW-1:0];
		wmode = pwdata[flash_pkg::FC0_MODE_LO +: 3];
		{hit, ridx} = decode(paddr);

		// One wait state: answer on the second access cycle
		setup = psel && penable && !ctl_ff.pready;
		access = psel && penable && ctl_ff.pready;
		nxt_ctl.pready = setup;
		if (setup) begin
			nxt_ctl.prdata = hit ? {24'h000000, reg_value(ctl_ff, ridx)} : 32'h00000000;
			nxt_ctl.pslverr = !hit;
		end

		if (access && pwrite && hit) begin
			case (ridx)
				flash_pkg::IDX_FLASH_ADDRESS_LOW: nxt_ctl.addr[7:0] = pwdata[7:0];
				flash_pkg::IDX_FLASH_ADDRESS_HIGH: nxt_ctl.addr[flash_pkg::FA_W-1:8] = pwdata[5:0];
				flash_pkg::IDX_FIRST_DATA_HIGH: begin
					nxt_ctl.fd[ridx] = pwdata[7:0];
					// Filling only while idle keeps the clear walk sole owner of the port
					if (ctl_ff.erase_write_enabled_flag && ctl_ff.st == flash_pkg::ST_IDLE) begin
						bp.we = 1'b1;
						if (page_off != flash_pkg::BUF_AW'(flash_pkg::BUF_DEPTH - 1)) begin
							nxt_ctl.addr = ctl_ff.addr + flash_pkg::FA_W'(1);
						end
					end
				end
				flash_pkg::IDX_FC0: begin
					nxt_ctl.mode = wmode;
					nxt_ctl.read_enable_bit = pwdata[flash_pkg::FC0_READ_ENABLE_BIT];
					if (!pwdata[flash_pkg::FC0_ERASE_WRITE_ENABLED_FLAG]) begin
						nxt_ctl.erase_write_enabled_flag = 1'b0;
					end
					if (pwdata[flash_pkg::FC0_UNLOCK_SEQUENCE_TRIGGER] && !ctl_ff.unlock_sequence_trigger
						&& wmode == flash_pkg::MODE_UNLOCK) begin
						nxt_ctl.unlock_sequence_trigger = 1'b1;
						unlock_load = 1'b1;
					end
					// Reserved modes and all-three writes start nothing; a cleared enabled flag blocks erase and write but not read
					if (ctl_ff.st == flash_pkg::ST_IDLE && !(pwdata[flash_pkg::FC0_FWT]
						&& pwdata[flash_pkg::FC0_READ_ENABLE_BIT] && pwdata[flash_pkg::FC0_FRD])) begin
						if (pwdata[flash_pkg::FC0_FWT] && ctl_ff.erase_write_enabled_flag
							&& wmode == flash_pkg::MODE_WRITE) begin
							nxt_ctl.write_start_bit = 1'b1;
							nxt_ctl.stall = 1'b1;
							nxt_ctl.idx = '0;
							nxt_ctl.st = flash_pkg::ST_WRITE;
						end else if (pwdata[flash_pkg::FC0_FWT] && ctl_ff.erase_write_enabled_flag
							&& wmode == flash_pkg::MODE_ERASE) begin
							nxt_ctl.write_start_bit = 1'b1;
							nxt_ctl.stall = 1'b1;
							nxt_ctl.st = flash_pkg::ST_ERASE;
						end else if (pwdata[flash_pkg::FC0_FRD] && pwdata[flash_pkg::FC0_READ_ENABLE_BIT]
							&& wmode == flash_pkg::MODE_READ) begin
							nxt_ctl.read_start_bit = 1'b1;
							nxt_ctl.stall = 1'b1;
							nxt_ctl.st = flash_pkg::ST_READ;
						end
					end
				end
				flash_pkg::IDX_FC1: begin
					nxt_ctl.fc1 = pwdata[7:0];
					nxt_ctl.chip_rst = (pwdata[7:0] == flash_pkg::RESET_KEY);
				end
				flash_pkg::IDX_FC2: begin
					if (pwdata[flash_pkg::FC2_BUFFER_CLEAR_BIT] && ctl_ff.st == flash_pkg::ST_IDLE) begin
						nxt_ctl.buffer_clear_bit = 1'b1;
						nxt_ctl.idx = '0;
						nxt_ctl.st = flash_pkg::ST_CLEAR;
					end
				end
				default: nxt_ctl.fd[ridx] = pwdata[7:0];
			endcase
		end

		case (ctl_ff.st)
			flash_pkg::ST_IDLE: begin
				// Keep the state chosen by a start request in this cycle
				nxt_ctl.st = nxt_ctl.st;
			end
			flash_pkg::ST_ERASE: begin
				// Array erases the addressed page to all zero words
				nxt_ctl.fl_erase = 1'b1;
				nxt_ctl.fl_addr = {ctl_ff.addr[flash_pkg::FA_W-1:flash_pkg::PAGE_LSB],
					flash_pkg::BUF_AW'(0)};
				op_load = 1'b1;
				nxt_ctl.st = flash_pkg::ST_WAIT_ER;
			end
			flash_pkg::ST_WAIT_ER: begin
				if (op_exp) begin
					nxt_ctl.write_start_bit = 1'b0;
					nxt_ctl.stall = 1'b0;
					nxt_ctl.st = flash_pkg::ST_IDLE;
				end
			end
			flash_pkg::ST_WRITE: begin
				// Buffer data lag one cycle behind the read address
				if (ctl_ff.idx != '0) begin
					nxt_ctl.fl_prog = 1'b1;
					nxt_ctl.fl_addr = {ctl_ff.addr[flash_pkg::FA_W-1:flash_pkg::PAGE_LSB],
						ctl_ff.idx[flash_pkg::BUF_AW-1:0] - flash_pkg::BUF_AW'(1)};
					nxt_ctl.fl_wdata = bp.rdata;
				end
				if (ctl_ff.idx == flash_pkg::IDX_W'(flash_pkg::BUF_DEPTH)) begin
					op_load = 1'b1;
					nxt_ctl.st = flash_pkg::ST_WAIT_WR;
				end else begin
					nxt_ctl.idx = ctl_ff.idx + flash_pkg::IDX_W'(1);
				end
			end
			flash_pkg::ST_WAIT_WR: begin
				if (op_exp) begin
					nxt_ctl.idx = '0;
					nxt_ctl.st = flash_pkg::ST_CLEAR;
				end
			end
			flash_pkg::ST_CLEAR: begin
				bp.we = 1'b1;
				bp.waddr = ctl_ff.idx[flash_pkg::BUF_AW-1:0];
				bp.wdata = '0;
				if (ctl_ff.idx == flash_pkg::IDX_W'(flash_pkg::BUF_DEPTH - 1)) begin
					nxt_ctl.write_start_bit = 1'b0;
					nxt_ctl.buffer_clear_bit = 1'b0;
					nxt_ctl.stall = 1'b0;
					nxt_ctl.st = flash_pkg::ST_IDLE;
				end else begin
					nxt_ctl.idx = ctl_ff.idx + flash_pkg::IDX_W'(1);
				end
			end
			flash_pkg::ST_READ: begin
				nxt_ctl.fl_read = 1'b1;
				nxt_ctl.fl_addr = ctl_ff.addr;
				op_value = flash_pkg::TMR_W'(READ_CYCLES);
				op_load = 1'b1;
				nxt_ctl.st = flash_pkg::ST_WAIT_RD;
			end
			flash_pkg::ST_WAIT_RD: begin
				op_value = flash_pkg::TMR_W'(READ_CYCLES);
				if (op_exp) begin
					nxt_ctl.fd[flash_pkg::IDX_FIRST_DATA_LOW] = flash_rdata[7:0];
					nxt_ctl.fd[flash_pkg::IDX_FIRST_DATA_HIGH] = flash_rdata[15:8];
					nxt_ctl.read_start_bit = 1'b0;
					nxt_ctl.stall = 1'b0;
					nxt_ctl.st = flash_pkg::ST_IDLE;
				end
			end
			default: nxt_ctl.st = flash_pkg::ST_IDLE;
		endcase

		// Placed last so the hardware set wins over a software clear
		if (unlock_exp) begin
			nxt_ctl.unlock_sequence_trigger = 1'b0;
			if (key_ok(ctl_ff)) begin
				nxt_ctl.erase_write_enabled_flag = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_ff <= '0;
		end else if (ce) begin
			ctl_ff <= nxt_ctl;
		end
	end

	assign prdata = ctl_ff.prdata;
	assign pready = ctl_ff.pready;
	assign pslverr = ctl_ff.pslverr;
	assign flash_addr = ctl_ff.fl_addr;
	assign flash_wdata = ctl_ff.fl_wdata;
	assign flash_prog = ctl_ff.fl_prog;
	assign flash_erase = ctl_ff.fl_erase;
	assign flash_read = ctl_ff.fl_read;
	assign cpu_stall = ctl_ff.stall;
	assign chip_reset = ctl_ff.chip_rst;
endmodule

// ---- design/write_buffer_mem.sv ----
module write_buffer_mem #(
	parameter int AW    = flash_pkg::BUF_AW,
	parameter int DW    = flash_pkg::WORD_W,
	parameter int DEPTH = flash_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire logic      ce,
	// Buffer port
	buffer_port_if.mem     bp
);
	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] word;
		logic [DW-1:0]            rdata;
	} mem_state_t;

	mem_state_t mem_ff;
	mem_state_t nxt_mem;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_mem.rdata = mem_ff.word[bp.raddr];
		if (bp.we) begin
			nxt_mem.word[bp.waddr] = bp.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ff <= '0;
		end else if (ce) begin
			mem_ff <= nxt_mem;
		end
	end

	assign bp.rdata = mem_ff.rdata;
endmodule

// ---- tb/flash_ctl_chk.sv ----
module flash_ctl_chk (
	// Clock and reset
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire logic                          ce,
	// Bus
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [flash_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0]                   pwdata,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	// Flash and system
	input wire logic [flash_pkg::FA_W-1:0]    flash_addr,
	input wire logic                          flash_prog,
	input wire logic                          flash_erase,
	input wire logic                          flash_read,
	input wire logic                          cpu_stall,
	input wire logic                          chip_reset
);
	logic unm;
	assign unm = (paddr[1:0] != 2'h0) || (paddr > 8'h30);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	bus_pulse_a: assert property (pready && ce |=> !pready)
		else $error("pready held longer than one cycle");
	bus_phase_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	slverr_map_a: assert property (pready |-> pslverr == unm)
		else $error("pslverr does not follow the address map");
	clr_upper_a: assert property (pready && !pwrite && paddr == 8'h30 |-> prdata[7:1] == 7'h0)
		else $error("upper bits of buffer clear register not zero");
	reset_key_a: assert property (psel && penable && pready && pwrite && paddr == 8'h2c
		&& pwdata[7:0] == 8'h55 |-> ##[1:2] chip_reset)
		else $error("chip reset missing after key write");
	reset_pulse_a: assert property (chip_reset |=> !chip_reset)
		else $error("chip reset longer than one cycle");
	erase_base_a: assert property (flash_erase |-> flash_addr[5:0] == 6'h0 ##1 !flash_erase)
		else $error("erase not a page base pulse");
	prog_stall_a: assert property (flash_prog |-> cpu_stall)
		else $error("word programmed while cpu runs");
	read_stall_a: assert property (flash_read |=> cpu_stall)
		else $error("read without cpu stall");
	ce_freeze_a: assert property (!ce |=> $stable(flash_addr) && $stable(cpu_stall))
		else $error("state moved while clock enable low");

	cover property (flash_erase);
	cover property (flash_prog ##1 !flash_prog);
	cover property (chip_reset);
endmodule

bind flash_self_program_control flash_ctl_chk i_flash_ctl_chk (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .flash_addr(flash_addr), .flash_prog(flash_prog),
	.flash_erase(flash_erase), .flash_read(flash_read), .cpu_stall(cpu_stall),
	.chip_reset(chip_reset)
);

// ---- tb/test_flash_self_program_control.sv ----
module test_flash_self_program_control;
	timeunit 1ns;
	timeprecision 1ps;
	// Unlock timer must outlast six bus writes
	localparam logic [7:0] AL  = {2'b00, flash_pkg::IDX_FLASH_ADDRESS_LOW, 2'b00};
	localparam logic [7:0] AH  = {2'b00, flash_pkg::IDX_FLASH_ADDRESS_HIGH, 2'b00};
	localparam logic [7:0] D0L = {2'b00, flash_pkg::IDX_FIRST_DATA_LOW, 2'b00};
	localparam logic [7:0] D0H = {2'b00, flash_pkg::IDX_FIRST_DATA_HIGH, 2'b00};
	localparam logic [7:0] C0  = {2'b00, flash_pkg::IDX_FC0, 2'b00};
	localparam logic [7:0] C1  = {2'b00, flash_pkg::IDX_FC1, 2'b00};
	localparam logic [7:0] C2  = {2'b00, flash_pkg::IDX_FC2, 2'b00};
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, se;
	logic        flash_prog, flash_erase, flash_read, cpu_stall, chip_reset;
	logic [7:0]  paddr, d, r1, r2, pg, pg_prog;
	logic [31:0] pwdata, prdata, rv;
	logic [13:0] flash_addr, rd_addr, er_addr;
	logic [15:0] flash_wdata, flash_rdata, w;
	logic [15:0] got_buf [64];
	logic [15:0] exp_buf [64];
	logic [7:0]  keys [6] = '{flash_pkg::KEY_SECOND_DATA_LOW, flash_pkg::KEY_SECOND_DATA_HIGH, flash_pkg::KEY_THIRD_DATA_LOW,
		flash_pkg::KEY_THIRD_DATA_HIGH, flash_pkg::KEY_FOURTH_DATA_LOW, flash_pkg::KEY_FOURTH_DATA_HIGH};
	logic [2:0]  rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
	int          err_count = 0, compares = 0, n_prog = 0, n_er = 0, n_rd = 0, n_rst = 0, i;

	flash_self_program_control #(.OP_CYCLES(20), .READ_CYCLES(4), .UNLOCK_CYCLES(64))
	i_flash_self_program_control (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_prog(flash_prog), .flash_erase(flash_erase), .flash_read(flash_read),
		.flash_rdata(flash_rdata), .cpu_stall(cpu_stall), .chip_reset(chip_reset)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (flash_prog === 1'b1) begin
			got_buf[flash_addr[5:0]] <= flash_wdata;
			pg_prog <= flash_addr[13:6];
			n_prog <= n_prog + 1;
		end
		if (flash_erase === 1'b1) begin
			er_addr <= flash_addr;
			n_er <= n_er + 1;
		end
		if (flash_read === 1'b1) begin
			rd_addr <= flash_addr;
			n_rd <= n_rd + 1;
		end
		if (chip_reset === 1'b1) n_rst <= n_rst + 1;
	end

	function automatic logic [7:0] ba(input int k);
		return 8'(k * 4);
	endfunction

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [7:0] dv);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, dv};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) err_count++;
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] dv);
		apb(1'b1, a, dv);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h0);
		chk("register", rv, {24'h0, e});
	endtask

	// Bounded poll so a stuck status bit ends in a mismatch, not a hang
	task poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 8'h0);
			n++;
		end while (rv[b] !== 1'b0 && n < 400);
		chk("status bit clear", rv[b], 1'b0);
	endtask

	task unlock(input logic [7:0] bad);
		wr(C0, 8'h68);
		rd(C0, 8'h68);
		for (i = 0; i < 6; i++) wr(ba(i + 4), keys[i] ^ ((i == 5) ? bad : 8'h00));
		poll(C0, flash_pkg::FC0_UNLOCK_SEQUENCE_TRIGGER);
	endtask

	task wrap_up;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#800000;
		err_count++;
		wrap_up;
	end

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, flash_rdata} = '0;
		void'($urandom(32'h939b392f));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 13; i++) rd(ba(i), 8'h00);
		for (i = 0; i < 10; i++) begin
			d = 8'($urandom);
			wr(ba(i), d);
			rd(ba(i), (i == 1) ? (d & 8'h3f) : d);
		end
		wr(8'h34, 8'hff);
		chk("pslverr", se, 1'b1);
		rd(8'h29, 8'h00);
		chk("pslverr", se, 1'b1);
		wr(C2, 8'hfe);
		rd(C2, 8'h00);
		wr(C0, 8'h80);
		rd(C0, 8'h00);
		wr(C0, 8'h14);
		repeat (4) @(posedge pclk);
		chk("erase count", n_er, 0);
		rd(C0, 8'h10);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		unlock(8'h01);
		rd(C0, 8'h60);
		unlock(8'h00);
		rd(C0, 8'he0);
		wr(C2, 8'h01);
		rd(C2, 8'h01);
		poll(C2, flash_pkg::FC2_BUFFER_CLEAR_BIT);
		for (i = 0; i < 64; i++) exp_buf[i] = 16'h0;
		pg = 8'($urandom);
		wr(AL, {pg[1:0], 6'h3c});
		wr(AH, {2'b00, pg[7:2]});
		wr(C0, 8'h94);
		repeat (3) @(posedge pclk);
		chk("stall", cpu_stall, 1'b1);
		poll(C0, flash_pkg::FC0_FWT);
		chk("stall", cpu_stall, 1'b0);
		chk("erase count", n_er, 1);
		chk("erase addr", er_addr, {pg, 6'h0});
		wr(C0, 8'h80);
		for (i = 0; i < 5; i++) begin
			w = 16'($urandom);
			wr(D0L, w[7:0]);
			wr(D0H, w[15:8]);
			exp_buf[(i < 4) ? 60 + i : 63] = w;
		end
		rd(AL, {pg[1:0], 6'h3f});
		wr(C0, 8'h84);
		poll(C0, flash_pkg::FC0_FWT);
		chk("prog count", n_prog, 64);
		chk("prog page", pg_prog, pg);
		for (i = 0; i < 64; i++) chk("word", got_buf[i], exp_buf[i]);
		wr(C0, 8'h84);
		poll(C0, flash_pkg::FC0_FWT);
		for (i = 0; i < 64; i++) chk("cleared word", got_buf[i], 16'h0);
		wr(C0, 8'h87);
		repeat (6) @(posedge pclk);
		chk("prog count", n_prog + n_rd, 128);
		for (i = 0; i < 4; i++) begin
			wr(C0, {1'b1, rsv[i], 4'h4});
			repeat (4) @(posedge pclk);
			chk("start count", n_prog + n_er, 129);
			rd(C0, {1'b1, rsv[i], 4'h0});
		end
		r1 = 8'($urandom);
		r2 = 8'($urandom) & 8'h3f;
		wr(AL, r1);
		wr(AH, r2);
		flash_rdata <= 16'($urandom);
		wr(C0, 8'hb3);
		poll(C0, flash_pkg::FC0_FRD);
		rd(D0L, flash_rdata[7:0]);
		rd(D0H, flash_rdata[15:8]);
		chk("read addr", rd_addr, {r2[5:0], r1});
		wr(C0, 8'hb1);
		repeat (8) @(posedge pclk);
		chk("read count", n_rd, 1);
		wr(C0, 8'h00);
		rd(C0, 8'h00);
		wr(C0, 8'h04);
		repeat (6) @(posedge pclk);
		chk("start count", n_prog + n_er, 129);
		wr(C1, 8'haa);
		rd(C1, 8'haa);
		chk("chip reset", n_rst, 0);
		wr(C1, 8'h55);
		repeat (3) @(posedge pclk);
		chk("chip reset", n_rst, 1);
		wrap_up;
	end
endmodule
